// *** rtl/ctrl_port_pins.sv ***
// Control port pin logic: I2C/SPI pin sharing, SPI slave framing, self-boot, clock out
`timescale 1ns/1ps
module ctrl_port_pins
   import ctrl_port_pkg::*;
#(
   parameter int ADDR_BYTES = ctrl_port_pkg::SPI_ADDR_BYTES   // Register address bytes per transaction
) (
   // System clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Mode strap: high selects I2C, low selects SPI
   input  wire logic        i2c_mode,
   // Address straps; high strap also carries SPI input data
   input  wire logic        addr_select_low,
   input  wire logic        addr_select_high,
   // SPI latch and shared serial clock pin (also SCL level)
   input  wire logic        spi_latch_n,
   input  wire logic        spi_ctrl_clock,
   output logic             scl_out,
   output logic             scl_oe,
   // Shared data pin (SDA in I2C, readout in SPI)
   input  wire logic        spi_readout_in,
   output logic             spi_readout_out,
   output logic             spi_readout_oe,
   // Straps for boot and output clock
   input  wire logic        boot_from_eeprom_sel,
   input  wire logic        outclk_freq_sel0,
   input  wire logic        outclk_freq_sel1,
   output logic             master_clock_out,
   // I2C engine side, clk domain
   input  wire logic        i2c_sda_pull_low,
   input  wire logic        i2c_scl_pull_low,
   output logic             i2c_sda_level,
   output logic             i2c_scl_level,
   output logic [6:0]       i2c_dev_addr,
   // Boot sequencing, clk domain
   input  wire logic        boot_done,
   output logic             self_boot_active,
   output logic             ctrl_port_ready,
   output logic             spi_frame_busy,
   // SPI user side, spi_ctrl_clock domain
   output logic [8*ADDR_BYTES-1:0] spi_reg_addr,
   output logic [7:0]       spi_wr_data,
   output logic             spi_wr_valid,
   output logic             spi_rd_req,
   input  wire logic [7:0]  spi_rd_data
);
   import ctrl_port_pkg::*;

   initial
   begin
      // The address shift keeps all but the oldest byte, so one byte alone has no slice to keep
      if (ADDR_BYTES < 2 || ADDR_BYTES > 4) $error("ctrl_port_pins: ADDR_BYTES must be 2 to 4");
   end

   // ---------------- clk domain ----------------
   logic [6:0]  strap_s;                    // Synchronised straps and pins
   logic        mode_s;                     // I2C mode, clk domain
   logic        lo_s;                       // Low address strap
   logic        hi_s;                       // High address strap
   logic        boot_s;                     // Self-boot strap
   logic [1:0]  fsel_s;                     // Output clock strap code
   logic        latch_s;                    // Latch level, clk domain

   level_sync #(.WIDTH(7)) u_sync_clk (
      .clk      (clk),
      .nrst     (nrst),
      .async_in ({i2c_mode, addr_select_low, addr_select_high, boot_from_eeprom_sel,
                  outclk_freq_sel1, outclk_freq_sel0, spi_latch_n}),
      .sync_out (strap_s)
   );
   assign {mode_s, lo_s, hi_s, boot_s, fsel_s, latch_s} = strap_s;

   logic [1:0]  pin_s;                      // SDA and SCL pin levels
   level_sync #(.WIDTH(2)) u_sync_pins (
      .clk      (clk),
      .nrst     (nrst),
      .async_in ({spi_readout_in, spi_ctrl_clock}),
      .sync_out (pin_s)
   );
   assign i2c_sda_level = pin_s[1];
   assign i2c_scl_level = pin_s[0];

   // I2C address from the two straps
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         i2c_dev_addr <= 7'h00;
      else
         i2c_dev_addr <= {I2C_ADDR_BASE, hi_s, lo_s};
   end

   // Frame busy seen from the clk domain
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         spi_frame_busy <= 1'b0;
      else
         spi_frame_busy <= ~mode_s & ~latch_s;
   end

   // Boot sequencing: settle, catch strap, then boot or wait for control
   boot_state_t state_ff;                   // Current boot state
   logic [1:0]  settle_ff;                  // Strap settle counter

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_ff  <= ST_SETTLE;
         settle_ff <= 2'h0;
      end
      else
      begin
         case (state_ff)
            ST_SETTLE:
            begin
               settle_ff <= settle_ff + 2'h1;
               if (settle_ff == STRAP_SETTLE_CYC)
                  state_ff <= boot_s ? ST_BOOT : ST_CTRL;
            end
            ST_BOOT:
            begin
               if (boot_done)
                  state_ff <= ST_CTRL;
            end
            ST_CTRL:
               state_ff <= ST_CTRL;
            default:
               state_ff <= ST_SETTLE;
         endcase
      end
   end
   assign self_boot_active = (state_ff == ST_BOOT);
   assign ctrl_port_ready  = (state_ff == ST_CTRL);

   // SCL pin: input, driven low only as boot master
   assign scl_out = 1'b0;
   assign scl_oe  = mode_s & self_boot_active & i2c_scl_pull_low;

   // Master clock output divider
   logic [3:0]  div_ff;                     // Half-period counter
   logic [3:0]  half_lim;                   // Half-period limit for strap code

   always_comb
   begin
      case (fsel_s)
         2'h0:    half_lim = OUTCLK_HALF_00;
         2'h1:    half_lim = OUTCLK_HALF_01;
         2'h2:    half_lim = OUTCLK_HALF_10;
         default: half_lim = OUTCLK_HALF_11;
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         div_ff           <= 4'h0;
         master_clock_out <= 1'b0;
      end
      else if (div_ff >= half_lim)
      begin
         div_ff           <= 4'h0;
         master_clock_out <= ~master_clock_out;
      end
      else
         div_ff <= div_ff + 4'h1;
   end

   // ---------------- link domain ----------------
   logic        frame_rst_n;                // Link logic held while latch is high
   logic [1:0]  link_s;                     // Mode and low strap in link domain
   logic        mode_l;                     // I2C mode, link domain
   logic        lo_l;                       // Low strap, link domain
   assign frame_rst_n = nrst & ~spi_latch_n;

   level_sync #(.WIDTH(2)) u_sync_link (
      .clk      (spi_ctrl_clock),
      .nrst     (nrst),
      .async_in ({i2c_mode, addr_select_low}),
      .sync_out (link_s)
   );
   assign {mode_l, lo_l} = link_s;

   logic [2:0]  bit_ff;                     // Bit within byte
   logic [2:0]  byte_ff;                    // Byte index, saturates in data phase
   logic [6:0]  shift_ff;                   // Incoming bits of current byte
   logic        sel_ff;                     // Chip byte matched this device
   logic        rd_ff;                      // Transaction is a read
   logic        rd_active_ff;               // Read data phase running
   logic [7:0]  tx_ff;                      // Outgoing readback byte
   logic [7:0]  rx_byte;                    // Completed byte this edge
   logic        byte_end;                   // Last bit of a byte this edge
   logic        data_ph;                    // Address bytes already received
   logic        spi_in;                     // SPI data input on the high strap pin

   assign spi_in   = addr_select_high;
   assign rx_byte  = {shift_ff, spi_in};
   assign byte_end = (bit_ff == 3'(SPI_BYTE_BITS - 1));
   assign data_ph  = (byte_ff > 3'(ADDR_BYTES));

   // Rising edge: shift in, count bytes, decode chip byte
   always_ff @(posedge spi_ctrl_clock or negedge frame_rst_n)
   begin
      if (!frame_rst_n)
      begin
         bit_ff       <= 3'h0;
         byte_ff      <= 3'h0;
         shift_ff     <= 7'h00;
         sel_ff       <= 1'b0;
         rd_ff        <= 1'b0;
         rd_active_ff <= 1'b0;
         spi_reg_addr <= '0;
         spi_wr_data  <= 8'h00;
         spi_wr_valid <= 1'b0;
         spi_rd_req   <= 1'b0;
      end
      else
      begin
         bit_ff       <= bit_ff + 3'h1;
         shift_ff     <= rx_byte[6:0];
         spi_wr_valid <= 1'b0;
         spi_rd_req   <= 1'b0;
         if (byte_end && !mode_l)
         begin
            if (!data_ph)
               byte_ff <= byte_ff + 3'h1;
            if (byte_ff == 3'h0)
            begin
               sel_ff <= (rx_byte[SPI_SEL_BIT] == lo_l);
               rd_ff  <= rx_byte[SPI_RW_BIT];
            end
            else if (!data_ph)
            begin
               spi_reg_addr <= {spi_reg_addr[8*ADDR_BYTES-9:0], rx_byte};
               if (byte_ff == 3'(ADDR_BYTES) && sel_ff && rd_ff)
               begin
                  rd_active_ff <= 1'b1;
                  spi_rd_req   <= 1'b1;
               end
            end
            else if (sel_ff && !rd_ff)
            begin
               spi_wr_data  <= rx_byte;
               spi_wr_valid <= 1'b1;
            end
            else if (sel_ff)
               spi_rd_req <= 1'b1;
         end
      end
   end

   // Falling edge: load or shift readback byte
   always_ff @(negedge spi_ctrl_clock or negedge frame_rst_n)
   begin
      if (!frame_rst_n)
         tx_ff <= 8'h00;
      else if (rd_active_ff && bit_ff == 3'h0)
         tx_ff <= spi_rd_data;
      else
         tx_ff <= {tx_ff[6:0], 1'b0};
   end

   // Shared data pin: open-drain in I2C, three-state readout in SPI
   always_comb
   begin
      if (i2c_mode)
      begin
         spi_readout_out = 1'b0;
         spi_readout_oe  = i2c_sda_pull_low;
      end
      else
      begin
         spi_readout_out = tx_ff[7];
         spi_readout_oe  = rd_active_ff & ~spi_latch_n;
      end
   end

   // ---------------- checks ----------------
   property p_i2c_addr;
      @(posedge clk) disable iff (!nrst)
      1 |=> i2c_dev_addr[1:0] == {$past(hi_s), $past(lo_s)};
   endproperty
   a_i2c_addr: assert property (p_i2c_addr) else $error("I2C address not from straps");

   property p_chip_sel;
      @(posedge spi_ctrl_clock) disable iff (!frame_rst_n)
      (byte_end && byte_ff == 3'h0 && !mode_l) |=> sel_ff == ($past(rx_byte[SPI_SEL_BIT]) == $past(lo_l));
   endproperty
   a_chip_sel: assert property (p_chip_sel) else $error("SPI chip select mismatch");

   property p_rd_req;
      @(posedge spi_ctrl_clock) disable iff (!frame_rst_n)
      $rose(rd_active_ff) |-> spi_rd_req && sel_ff && rd_ff;
   endproperty
   a_rd_req: assert property (p_rd_req) else $error("Read phase began without request");

   property p_scl_od;
      @(posedge clk) disable iff (!nrst)
      !self_boot_active |-> !scl_oe && !scl_out;
   endproperty
   a_scl_od: assert property (p_scl_od) else $error("SCL driven outside self-boot");

   property p_sda_od;
      @(posedge clk) disable iff (!nrst)
      i2c_mode |-> spi_readout_oe == i2c_sda_pull_low && !spi_readout_out;
   endproperty
   a_sda_od: assert property (p_sda_od) else $error("SDA not open-drain");

   property p_readout_z;
      @(posedge clk) disable iff (!nrst)
      (!i2c_mode && (spi_latch_n || !rd_active_ff)) |-> !spi_readout_oe;
   endproperty
   a_readout_z: assert property (p_readout_z) else $error("Readout driven outside read");

   property p_wr_data;
      @(posedge spi_ctrl_clock) disable iff (!frame_rst_n)
      (byte_end && data_ph && sel_ff && !rd_ff && !mode_l) |=> spi_wr_valid && spi_wr_data == $past(rx_byte);
   endproperty
   a_wr_data: assert property (p_wr_data) else $error("Write byte lost");

   property p_boot;
      @(posedge clk) disable iff (!nrst)
      (state_ff == ST_SETTLE && settle_ff == STRAP_SETTLE_CYC) |=> self_boot_active == $past(boot_s);
   endproperty
   a_boot: assert property (p_boot) else $error("Self-boot strap not honoured");

   property p_clkdiv;
      @(posedge clk) disable iff (!nrst)
      (div_ff >= half_lim) |=> master_clock_out != $past(master_clock_out) && div_ff == 4'h0;
   endproperty
   a_clkdiv: assert property (p_clkdiv) else $error("Output clock divider slip");

   c_boot:  cover property (@(posedge clk) disable iff (!nrst) $rose(self_boot_active));
   c_write: cover property (@(posedge spi_ctrl_clock) disable iff (!frame_rst_n) spi_wr_valid);
   c_read:  cover property (@(posedge spi_ctrl_clock) disable iff (!frame_rst_n) spi_rd_req ##8 spi_rd_req);
endmodule

// *** rtl/ctrl_port_pkg.sv ***
// Constants shared by the control port pin logic
package ctrl_port_pkg;
   // Byte and field layout of an SPI transaction
   localparam int            SPI_BYTE_BITS    = 8;          // Bits per SPI byte
   localparam int            SPI_ADDR_BYTES   = 2;          // Register address bytes after the chip byte
   localparam int            SPI_RW_BIT       = 0;          // Read/write flag inside the chip byte
   localparam int            SPI_SEL_BIT      = 1;          // Chip-select bit inside the chip byte
   // I2C address: upper bits fixed, two low bits from the address straps
   localparam logic [4:0]    I2C_ADDR_BASE    = 5'h0E;      // Upper five address bits, arbitrary value
   // Strap settling before the self-boot strap is caught
   localparam logic [1:0]    STRAP_SETTLE_CYC = 2'h3;       // Sync depth plus one
   // Master clock output divider half periods, by strap code
   localparam logic [3:0]    OUTCLK_HALF_00   = 4'h0;       // Divide by 2
   localparam logic [3:0]    OUTCLK_HALF_01   = 4'h1;       // Divide by 4
   localparam logic [3:0]    OUTCLK_HALF_10   = 4'h3;       // Divide by 8
   localparam logic [3:0]    OUTCLK_HALF_11   = 4'h7;       // Divide by 16
   // Boot sequencing states
   typedef enum logic [1:0] {ST_SETTLE, ST_BOOT, ST_CTRL} boot_state_t;
endpackage

// *** rtl/level_sync.sv ***
// Two-flop level synchroniser, one bit per lane
`timescale 1ns/1ps
module level_sync #(
   parameter int WIDTH = 1                  // Number of independent lanes
) (
   // Destination clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Asynchronous level in, synchronised level out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;               // First stage, read only by the second

   initial
   begin
      if (WIDTH < 1) $error("level_sync: WIDTH must be at least 1");
   end

   // Two stages in series
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_ff  <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule

// *** verification/spi_host_model.sv ***
// Host-side SPI master model for the shared control port pins
`timescale 1ns/1ps
module spi_host_model (
   // Pins driven towards the device
   output logic spi_latch_n,
   output logic host_clk,
   output logic host_data,
   // Readout pin level as seen on the board
   input  wire logic readout_pin
);
   // Idle: latch high, gated clock parked low
   initial
   begin
      spi_latch_n = 1'b1;
      host_clk    = 1'b0;
      host_data   = 1'b0;
   end
   // One framed transaction, MSB first, 6 ns clock
   task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
      logic [7:0] sh;
      rx = {};
      spi_latch_n = 1'b0;
      #3;
      foreach (tx[i])
      begin
         for (int b = 7; b >= 0; b--)
         begin
            host_data = tx[i][b];    // Data moves while clock is low
            #3 host_clk = 1'b1;
            sh = {sh[6:0], readout_pin};
            #3 host_clk = 1'b0;
         end
         rx.push_back(sh);
      end
      // Trailing pulse so the last byte's strobe shows
      #3 host_clk = 1'b1;
      #3 host_clk = 1'b0;
      #3 spi_latch_n = 1'b1;
      host_data = ~host_data;        // Released line keeps no stale value
      #6;
   endtask
   // Free-running clock between frames
   task automatic idle_clocks(input int n);
      repeat (n)
      begin
         #3 host_clk = 1'b1;
         #3 host_clk = 1'b0;
      end
   endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the control port pin logic
`timescale 1ns/1ps
module tb_top;
   import ctrl_port_pkg::*;
   // Bench-driven inputs
   logic        clk, nrst, i2c_mode, addr_select_low, strap_high, boot_from_eeprom_sel;
   logic        outclk_freq_sel0, outclk_freq_sel1, i2c_sda_pull_low, i2c_scl_pull_low, boot_done;
   // Device outputs and board nets
   wire logic   spi_latch_n, host_clk, host_data, scl_out, scl_oe, rd_out, rd_oe, master_clock_out;
   wire logic   i2c_sda_level, i2c_scl_level, self_boot_active, ctrl_port_ready, spi_frame_busy;
   wire logic   spi_wr_valid, spi_rd_req;
   wire logic [6:0]  i2c_dev_addr;
   wire logic [15:0] spi_reg_addr;
   wire logic [7:0]  spi_wr_data, spi_rd_data;
   // Bookkeeping
   int          failures, check_count, rd_idx;
   logic [31:0] seed;
   logic [7:0]  rd_tab[4];
   logic [23:0] exp_q[$];
   // Shared pins resolved with board pull-ups
   wire logic   spi_ctrl_clock   = i2c_mode ? ~scl_oe : host_clk;
   wire logic   addr_select_high = i2c_mode ? strap_high : host_data;
   wire logic   readout_pin      = rd_oe ? rd_out : 1'b1;
   assign spi_rd_data = rd_tab[rd_idx[1:0]];

   ctrl_port_pins #(.ADDR_BYTES(2)) i_ctrl_port_pins (.clk(clk), .nrst(nrst), .i2c_mode(i2c_mode),
      .addr_select_low(addr_select_low), .addr_select_high(addr_select_high), .spi_latch_n(spi_latch_n),
      .spi_ctrl_clock(spi_ctrl_clock), .scl_out(scl_out), .scl_oe(scl_oe), .spi_readout_in(readout_pin),
      .spi_readout_out(rd_out), .spi_readout_oe(rd_oe), .boot_from_eeprom_sel(boot_from_eeprom_sel),
      .outclk_freq_sel0(outclk_freq_sel0), .outclk_freq_sel1(outclk_freq_sel1),
      .master_clock_out(master_clock_out), .i2c_sda_pull_low(i2c_sda_pull_low),
      .i2c_scl_pull_low(i2c_scl_pull_low), .i2c_sda_level(i2c_sda_level), .i2c_scl_level(i2c_scl_level),
      .i2c_dev_addr(i2c_dev_addr), .boot_done(boot_done), .self_boot_active(self_boot_active),
      .ctrl_port_ready(ctrl_port_ready), .spi_frame_busy(spi_frame_busy), .spi_reg_addr(spi_reg_addr),
      .spi_wr_data(spi_wr_data), .spi_wr_valid(spi_wr_valid), .spi_rd_req(spi_rd_req),
      .spi_rd_data(spi_rd_data));
   spi_host_model i_spi_host_model (.spi_latch_n(spi_latch_n), .host_clk(host_clk),
      .host_data(host_data), .readout_pin(readout_pin));

   // 20 MHz system clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   // Verdict and end of run
   task automatic wrap_up();
      $display("failures=%0d checks=%0d", failures, check_count);
      if (failures == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Step to just after a rising edge
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge clk);
         #2;
      end
   endtask
   // Reset with a given boot strap
   task automatic do_reset(input logic boot);
      nrst = 1'b0;
      boot_from_eeprom_sel = boot;
      tick(3);
      chk({master_clock_out, ctrl_port_ready, i2c_dev_addr}, 0, "reset values");
      nrst = 1'b1;
      tick(6);
   endtask
   // Next read byte served on each request
   always @(posedge spi_rd_req)
      rd_idx <= rd_idx + 1;
   // Monitor: oldest expected write against each strobe
   always @(negedge spi_ctrl_clock)
   begin
      if (spi_wr_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk(1, 0, "unexpected write strobe");
         else
            chk({spi_reg_addr, spi_wr_data}, exp_q.pop_front(), "write mismatch");
      end
   end
   // Write frame; hit selects a matching chip byte
   task automatic spi_write(input logic hit);
      logic [7:0]  tx[$];
      logic [7:0]  rx[$];
      logic [31:0] r;
      r = $random(seed);
      tx = '{{6'h15, hit ~^ addr_select_low, 1'b0}, r[23:16], r[15:8], r[7:0]};
      if (hit)
         exp_q.push_back(r[23:0]);
      i_spi_host_model.frame(tx, rx);
      chk(rd_oe, 0, "readout driven after write");
   endtask
   // Read frame of two data bytes
   task automatic spi_read();
      logic [7:0]  tx[$];
      logic [7:0]  rx[$];
      logic [31:0] r;
      r = $random(seed);
      rd_tab = '{r[7:0], r[15:8], r[23:16], r[31:24]};
      rd_idx = 0;
      tx = '{{6'h2A, addr_select_low, 1'b1}, r[31:24], r[7:0], 8'h00, 8'h00};
      fork
         i_spi_host_model.frame(tx, rx);
         // Second bit of the first data byte: readout must drive, busy must show
         begin
            repeat (26) @(posedge host_clk);
            #1;
            chk(rd_oe, 1, "readout idle during read");
            chk(spi_frame_busy, 1, "frame busy not seen");
         end
      join
      chk(rx[3], rd_tab[1], "readback byte 0");
      chk(rx[4], rd_tab[2], "readback byte 1");
      chk(rd_oe, 0, "readout driven after read");
   endtask
   // Watchdog
   initial
   begin
      #300000;
      failures++;
      $display("BAD %0t timeout", $time);
      wrap_up();
   end
   // Main sequence
   initial
   begin
      time t0;
      seed = 32'h391D;
      {nrst, i2c_mode, addr_select_low, strap_high, boot_from_eeprom_sel} = 5'h08;
      {outclk_freq_sel0, outclk_freq_sel1, i2c_sda_pull_low, i2c_scl_pull_low, boot_done} = 5'h00;
      failures = 0;
      check_count = 0;
      rd_idx = 0;
      rd_tab = '{8'h00, 8'h00, 8'h00, 8'h00};
      do_reset(1'b1);
      chk({self_boot_active, ctrl_port_ready}, 2'h2, "self-boot not started");
      i2c_scl_pull_low = 1'b1;
      tick(3);
      chk({scl_oe, scl_out, i2c_scl_level}, 3'h4, "boot clock not driven");
      boot_done = 1'b1;
      tick(1);
      boot_done = 1'b0;
      tick(2);
      chk({self_boot_active, ctrl_port_ready, scl_oe}, 3'h2, "boot end");
      i2c_scl_pull_low = 1'b0;
      for (int k = 0; k < 4; k++)
      begin
         {strap_high, addr_select_low} = k[1:0];
         tick(4);
         chk(i2c_dev_addr, {I2C_ADDR_BASE, k[1:0]}, "bus address");
      end
      i2c_sda_pull_low = 1'b1;
      tick(3);
      chk({rd_oe, rd_out, i2c_sda_level}, 3'h4, "data pull low");
      i2c_sda_pull_low = 1'b0;
      tick(3);
      chk({rd_oe, i2c_sda_level}, 2'h1, "data release");
      for (int k = 0; k < 4; k++)
      begin
         {outclk_freq_sel1, outclk_freq_sel0} = k[1:0];
         tick(40);
         @(posedge master_clock_out);
         t0 = $time;
         @(posedge master_clock_out);
         chk(32'(($time - t0) / 50), 32'(2 << k), "output clock ratio");
         // Step off the clock edge before the next input change
         #2;
      end
      do_reset(1'b0);
      chk({self_boot_active, ctrl_port_ready}, 2'h1, "control wait");
      i2c_mode = 1'b0;
      for (int s = 0; s < 2; s++)
      begin
         addr_select_low = s[0];
         tick(4);
         spi_write(1'b1);
         spi_write(1'b0);
         spi_read();
         i_spi_host_model.idle_clocks(5);
         spi_write(1'b1);
      end
      tick(4);
      chk(exp_q.size(), 0, "missing write strobes");
      chk(spi_frame_busy, 0, "frame busy after latch high");
      wrap_up();
   end
endmodule
